// *** bench/agu_sva.sv ***
// port assertions for the load/store address unit
`timescale 1ns/1ps
`default_nettype none
module agu_sva
  import agu_pkg::*;
(
  input wire logic      clk_sys,
  input wire logic      rstn,
  input wire logic      op_valid,
  input wire logic      op_ready,
  input wire op_req_t   op_req,
  input wire logic      mem_req_valid,
  input wire logic      mem_req_ready,
  input wire mem_req_t  mem_req,
  input wire logic      mem_resp_valid,
  input wire mem_resp_t mem_resp,
  input wire logic      done,
  input wire exc_t      exception,
  input wire wb_t       wb_data,
  input wire wb_t       wb_addr
);
  logic        pend_ff;
  logic [1:0]  kind_ff;
  logic [31:0] addr_ff;
  logic        rd_ok;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  assign rd_ok = pend_ff && mem_resp_valid && !kind_ff[1] && !mem_resp.translation_miss
                 && !mem_resp.protection_violation;
  // tracks the access in flight
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      pend_ff <= 1'b0;
    else if (mem_req_valid && mem_req_ready)
      pend_ff <= 1'b1;
    else if (mem_resp_valid)
      pend_ff <= 1'b0;
  end
  always_ff @(posedge clk_sys)
  begin
    if (mem_req_valid && mem_req_ready)
    begin
      kind_ff <= {mem_req.write, mem_req.size_long};
      addr_ff <= mem_req.addr;
    end
  end
  illegal_slot_a: assert property (
    op_valid && op_ready && op_req.op == ld_long_pc && op_req.delay_slot
    |=> done && exception == illegal_slot_exception && !mem_req_valid)
    else $error("delay slot pc load not refused at once");
  long_align_a: assert property (
    mem_req_valid && mem_req.size_long |-> mem_req.addr[1:0] == 2'h0)
    else $error("misaligned long access issued");
  word_align_a: assert property (
    mem_req_valid && !mem_req.size_long |-> !mem_req.addr[0])
    else $error("misaligned word access issued");
  store_half_a: assert property (
    mem_req_valid && mem_req.write |-> !mem_req.size_long && mem_req.wdata[31:16] == 16'h0)
    else $error("store not a plain word");
  resp_done_a: assert property (
    pend_ff && mem_resp_valid |=> done)
    else $error("no done after response");
  fault_nowb_a: assert property (
    done && exception != no_exception |-> !wb_data.en && !wb_addr.en)
    else $error("writeback despite fault");
  word_sext_a: assert property (
    rd_ok && !kind_ff[0] |=> wb_data.en
    && wb_data.value == {{16{$past(mem_resp.rdata[15])}}, $past(mem_resp.rdata[15:0])})
    else $error("word load not sign extended");
  long_data_a: assert property (
    rd_ok && kind_ff[0] |=> wb_data.en && wb_data.value == $past(mem_resp.rdata))
    else $error("long load value altered");
  write_miss_a: assert property (
    pend_ff && mem_resp_valid && mem_resp.translation_miss && kind_ff[1]
    |=> exception == write_translation_miss)
    else $error("write miss not reported");
  addr_upd_a: assert property (
    done && wb_addr.en |-> wb_addr.value == addr_ff + (wb_data.en ? 32'h4 : 32'h0))
    else $error("address update wrong");
  busy_ready_a: assert property (
    mem_req_valid || pend_ff |-> !op_ready)
    else $error("new operation offered while busy");
  cover property (done && exception == illegal_slot_exception);
  cover property (done && wb_addr.en && !wb_data.en);
  cover property (mem_req_valid && !mem_req_ready);
endmodule // agu_sva
bind word_long_load_store_agu agu_sva agu_sva_i (.clk_sys(clk_sys), .rstn(rstn),
  .op_valid(op_valid), .op_ready(op_ready), .op_req(op_req), .mem_req_valid(mem_req_valid),
  .mem_req_ready(mem_req_ready), .mem_req(mem_req), .mem_resp_valid(mem_resp_valid),
  .mem_resp(mem_resp), .done(done), .exception(exception), .wb_data(wb_data),
  .wb_addr(wb_addr));
`default_nettype wire

// *** bench/mem_model.sv ***
// memory side model: grants and answers after set stalls, reports set faults
`timescale 1ns/1ps
`default_nettype none
module mem_model
  import agu_pkg::*;
#(
  parameter logic [31:0] KEY = 32'h5a5a_c3e1
)
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       mem_req_valid,
  input  wire mem_req_t   mem_req,
  input  wire logic [2:0] flt,
  input  wire logic [1:0] stall,
  output logic            mem_req_ready,
  output logic            mem_resp_valid,
  output mem_resp_t       mem_resp
);
  logic        pend_ff;
  logic [1:0]  cnt_ff;
  logic [31:0] addr_ff;
  assign mem_req_ready  = mem_req_valid && !pend_ff && cnt_ff == stall;
  assign mem_resp_valid = pend_ff && cnt_ff == stall;
  // outside the answer cycle the lines show inverted junk
  assign mem_resp = mem_resp_valid ? {flt, addr_ff ^ KEY} : {~flt, ~(addr_ff ^ KEY)};
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pend_ff <= 1'b0;
      cnt_ff  <= 2'h0;
      addr_ff <= 32'h0;
    end
    else if (mem_req_ready)
    begin
      pend_ff <= 1'b1;
      cnt_ff  <= 2'h0;
      addr_ff <= mem_req.addr;
    end
    else if (mem_resp_valid)
    begin
      pend_ff <= 1'b0;
      cnt_ff  <= 2'h0;
    end
    else if (mem_req_valid || pend_ff)
      cnt_ff <= cnt_ff + 2'h1;
  end
endmodule // mem_model
`default_nettype wire

// *** bench/test_word_long_load_store_agu.sv ***
// self-checking bench for the word and long-word load/store address unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module test_word_long_load_store_agu
  import agu_pkg::*;
;
  typedef struct packed {exc_t e; wb_t d; wb_t a;} res_t;
  localparam logic [31:0] KEY = 32'h5a5a_c3e1;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        op_valid = 1'b0;
  op_req_t     op_req = '0;
  logic [2:0]  flt = 3'h0;
  logic [1:0]  stall = 2'h0;
  logic [31:0] seed = 32'd86636;
  logic        op_ready, mem_req_valid, mem_req_ready, mem_resp_valid, done;
  mem_req_t    mem_req, mm;
  mem_resp_t   mem_resp;
  exc_t        exception;
  wb_t         wb_data, wb_addr;
  res_t        rr;
  int          n_fail = 0;
  int          total_checks = 0;
  mem_req_t    exp_mem[$];
  res_t        exp_res[$];
  always #2.5 clk_sys = ~clk_sys;
  word_long_load_store_agu word_long_load_store_agu_i (.clk_sys(clk_sys), .rstn(rstn),
    .op_valid(op_valid), .op_ready(op_ready), .op_req(op_req), .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready), .mem_req(mem_req), .mem_resp_valid(mem_resp_valid),
    .mem_resp(mem_resp), .done(done), .exception(exception), .wb_data(wb_data),
    .wb_addr(wb_addr));
  mem_model #(.KEY(KEY)) mem_model_i (.clk_sys(clk_sys), .rstn(rstn),
    .mem_req_valid(mem_req_valid), .mem_req(mem_req), .flt(flt), .stall(stall),
    .mem_req_ready(mem_req_ready), .mem_resp_valid(mem_resp_valid), .mem_resp(mem_resp));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one operation: expectations noted, request offered for one cycle, done awaited
  task automatic run(input op_t op);
    op_req_t     r;
    mem_req_t    m;
    res_t        x;
    logic        ld;
    logic [31:0] rd;
    int          i;
    r = '0;
    r.op = op;
    {r.source_register, r.destination_register, r.index_register_zero} = {xs(), xs(), xs()};
    {r.gbr, r.pc} = {xs(), xs()};
    r.imm = 8'(xs());
    r.m_sel = 4'(xs());
    r.n_sel = 4'(xs());
    r.delay_slot = xs() % 4 == 0;
    if (xs() % 4 != 0)
    begin
      r.source_register[1:0] = 2'h0;
      r.destination_register[1:0] = 2'h0;
      r.index_register_zero[1:0] = 2'h0;
      r.gbr[1:0] = 2'h0;
    end
    if (xs() % 4 == 0)
      r.m_sel = r.n_sel;
    ld = op inside {ld_long_indexed, ld_long_gbr, ld_long_pc, ld_long_disp, ld_long_postinc,
                    ld_word_indirect};
    m = '0;
    m.write = !ld;
    m.size_long = ld && op != ld_word_indirect;
    case (op)
      ld_long_indexed:  m.addr = r.index_register_zero + r.source_register;
      ld_long_gbr:      m.addr = r.gbr + {r.imm, 2'h0};
      ld_long_pc:       m.addr = ((r.pc + 32'h4) & ~32'h3) + {r.imm, 2'h0};
      ld_long_disp:     m.addr = r.source_register + {r.imm[3:0], 2'h0};
      st_word_indirect: m.addr = r.destination_register;
      st_word_predec:   m.addr = r.destination_register - 32'h2;
      st_word_indexed:  m.addr = r.index_register_zero + r.destination_register;
      st_word_gbr:      m.addr = r.gbr + {r.imm, 1'h0};
      st_word_disp:     m.addr = r.destination_register + {r.imm[3:0], 1'h0};
      default:          m.addr = r.source_register;
    endcase
    m.wdata = {16'h0, op inside {st_word_gbr, st_word_disp} ? r.index_register_zero[15:0]
                                                            : r.source_register[15:0]};
    rd = m.addr ^ KEY;
    x = '0;
    if (op == ld_long_pc && r.delay_slot)
      x.e = illegal_slot_exception;
    else if (m.size_long ? m.addr[1:0] != 2'h0 : m.addr[0])
      x.e = ld ? read_address_error : write_address_error;
    else
    begin
      exp_mem.push_back(m);
      if (flt[2])
        x.e = ld ? read_translation_miss : write_translation_miss;
      else if (flt[1])
        x.e = ld ? read_protection_violation : write_protection_violation;
      else if (flt[0] && !ld)
        x.e = first_write_exception;
      else
      begin
        x.d = '{ld, op == ld_long_gbr ? INDEX_ZERO_SEL : r.n_sel,
                m.size_long ? rd : {{16{rd[15]}}, rd[15:0]}};
        if (op == st_word_predec)
          x.a = '{1'b1, r.n_sel, m.addr};
        if (op == ld_long_postinc && r.m_sel != r.n_sel)
          x.a = '{1'b1, r.m_sel, r.source_register + 32'h4};
      end
    end
    exp_res.push_back(x);
    @(posedge clk_sys);
    #1 op_req = r;
    op_valid = 1'b1;
    @(posedge clk_sys);
    #1 op_valid = 1'b0;
    op_req = op_req_t'(~r);
    for (i = 0; i < 40 && done !== 1'b1; i++)
      @(negedge clk_sys);
    if (i == 40)
    begin
      n_fail++;
      finish_test();
    end
  endtask
  // compares each grant and each result with the oldest note
  always @(negedge clk_sys)
  begin
    if (mem_req_valid && mem_req_ready)
    begin
      `CHK(exp_mem.size() > 0, 1'b1)
      if (exp_mem.size() > 0)
      begin
        mm = exp_mem.pop_front();
        `CHK({mem_req.write, mem_req.size_long, mem_req.addr}, {mm.write, mm.size_long, mm.addr})
        if (mm.write) `CHK(mem_req.wdata, mm.wdata)
      end
    end
    if (done === 1'b1)
      `CHK(exp_res.size() > 0, 1'b1)
    if (done === 1'b1 && exp_res.size() > 0)
    begin
      rr = exp_res.pop_front();
      `CHK(exception, rr.e)
      `CHK({wb_data.en, wb_addr.en}, {rr.d.en, rr.a.en})
      if (rr.d.en) `CHK(wb_data, rr.d)
      if (rr.a.en) `CHK(wb_addr, rr.a)
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 400; i++)
    begin
      flt = xs() % 3 == 0 ? 3'(xs()) : 3'h0;
      stall = 2'(xs());
      run(op_t'(4'(i % 11)));
    end
    repeat (4) @(posedge clk_sys);
    finish_test();
  end
  initial
  begin
    #200us;
    n_fail++;
    finish_test();
  end
endmodule // test_word_long_load_store_agu
`default_nettype wire

// *** src/agu_ea_calc.sv ***
// effective address, store data and address update for one request
`timescale 1ns/1ps
`default_nettype none
module agu_ea_calc
  import agu_pkg::*;
(
  input  wire op_req_t  req,
  output mem_req_t      mem,
  output logic          is_load,
  output logic          misaligned,
  output logic [3:0]    dest_sel,
  output logic          upd_en,
  output logic [3:0]    upd_sel,
  output logic [31:0]   upd_value
);

  function automatic logic [31:0] scale_imm(input logic [7:0] imm, input logic wide,
                                            input int unsigned shift);
    logic [31:0] z;
    z = wide ? {24'h0, imm} : {28'h0, imm[3:0]};
    return z << shift;
  endfunction

  logic [31:0] pc_base;

  always_comb
  begin
    pc_base    = (req.pc + PC_ADVANCE) & PC_ALIGN_MASK;
    mem        = MEM_REQ_RESET;
    is_load    = 1'b1;
    dest_sel   = req.n_sel;
    upd_en     = 1'b0;
    upd_sel    = req.m_sel;
    upd_value  = 32'h0;
    mem.size_long = 1'b1;
    // every sum below is 32 bits wide and wraps silently
    case (req.op)
      ld_long_indexed:  mem.addr = req.index_register_zero + req.source_register;
      ld_long_gbr:
      begin
        mem.addr = req.gbr + scale_imm(req.imm, 1'b1, LONG_SHIFT);
        dest_sel = INDEX_ZERO_SEL;
      end
      ld_long_pc:       mem.addr = pc_base + scale_imm(req.imm, 1'b1, LONG_SHIFT);
      ld_long_disp:     mem.addr = req.source_register
                                   + scale_imm(req.imm, 1'b0, LONG_SHIFT);
      ld_long_postinc:
      begin
        mem.addr  = req.source_register;
        upd_en    = 1'b1;
        upd_value = req.source_register + LONG_STEP;
      end
      ld_word_indirect:
      begin
        mem.size_long = 1'b0;
        mem.addr      = req.source_register;
      end
      default:
      begin
        is_load       = 1'b0;
        mem.write     = 1'b1;
        mem.size_long = 1'b0;
        mem.wdata     = {16'h0, req.source_register[15:0]};
        case (req.op)
          st_word_indirect: mem.addr = req.destination_register;
          st_word_predec:
          begin
            mem.addr  = req.destination_register - WORD_STEP;
            upd_en    = 1'b1;
            upd_sel   = req.n_sel;
            upd_value = req.destination_register - WORD_STEP;
          end
          st_word_indexed:
            mem.addr = req.index_register_zero + req.destination_register;
          st_word_gbr:
          begin
            mem.addr  = req.gbr + scale_imm(req.imm, 1'b1, WORD_SHIFT);
            mem.wdata = {16'h0, req.index_register_zero[15:0]};
          end
          st_word_disp:
          begin
            mem.addr  = req.destination_register
                        + scale_imm(req.imm, 1'b0, WORD_SHIFT);
            mem.wdata = {16'h0, req.index_register_zero[15:0]};
          end
          default:  mem.addr = req.destination_register;
        endcase
      end
    endcase
    misaligned = mem.size_long ? ((mem.addr[1:0] & LONG_ALIGN) != 2'h0)
                               : ((mem.addr[1:0] & WORD_ALIGN) != 2'h0);
  end

endmodule // agu_ea_calc
`default_nettype wire

// *** src/agu_load_extend.sv ***
// shapes returned memory data into a register value
`timescale 1ns/1ps
`default_nettype none
module agu_load_extend
  import agu_pkg::*;
(
  input  wire logic [31:0] rdata,
  input  wire logic        size_long,
  output logic [31:0]      value
);

  always_comb
  begin
    if (size_long)
      value = rdata;
    else
      value = {{16{rdata[15]}}, rdata[15:0]};
  end

endmodule // agu_load_extend
`default_nettype wire

// *** src/agu_pkg.sv ***
// shared types and constants for the word and long-word load/store address unit
package agu_pkg;

  localparam int unsigned DATA_W         = 32;
  localparam int unsigned SEL_W          = 4;
  localparam logic [3:0]  INDEX_ZERO_SEL = 4'h0;
  localparam logic [31:0] PC_ADVANCE     = 32'h0000_0004;
  localparam logic [31:0] PC_ALIGN_MASK  = 32'hffff_fffc;
  localparam int unsigned LONG_SHIFT     = 2;
  localparam int unsigned WORD_SHIFT     = 1;
  localparam logic [31:0] LONG_STEP      = 32'h0000_0004;
  localparam logic [31:0] WORD_STEP      = 32'h0000_0002;
  localparam logic [1:0]  LONG_ALIGN     = 2'h3;
  localparam logic [1:0]  WORD_ALIGN     = 2'h1;
  localparam logic [1:0]  RESET_SYNC_INIT = 2'h0;

  typedef enum logic [3:0] {
    ld_long_indexed,
    ld_long_gbr,
    ld_long_pc,
    ld_long_disp,
    ld_long_postinc,
    st_word_indirect,
    st_word_predec,
    st_word_indexed,
    st_word_gbr,
    st_word_disp,
    ld_word_indirect
  } op_t;

  typedef enum logic [3:0] {
    no_exception,
    illegal_slot_exception,
    read_address_error,
    read_translation_miss,
    read_protection_violation,
    write_address_error,
    write_translation_miss,
    write_protection_violation,
    first_write_exception
  } exc_t;

  typedef struct packed {
    op_t         op;
    logic [31:0] source_register;
    logic [31:0] destination_register;
    logic [31:0] index_register_zero;
    logic [31:0] gbr;
    logic [31:0] pc;
    logic [7:0]  imm;
    logic [3:0]  m_sel;
    logic [3:0]  n_sel;
    logic        delay_slot;
  } op_req_t;

  typedef struct packed {
    logic        write;
    logic        size_long;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        translation_miss;
    logic        protection_violation;
    logic        first_write;
    logic [31:0] rdata;
  } mem_resp_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    logic [31:0] value;
  } wb_t;

  localparam mem_req_t MEM_REQ_RESET = '{write: 1'b0, size_long: 1'b0,
                                         addr: 32'h0, wdata: 32'h0};
  localparam wb_t      WB_RESET      = '{en: 1'b0, sel: 4'h0, value: 32'h0};

endpackage

// *** src/word_long_load_store_agu.sv ***
// address generation and sequencing for word and long-word load/store moves
// Overview of operation
// - indexed long load: index zero plus source, 32-bit value to destination
// - all address sums truncate to 32 bits and wrap without fault
// - base long load: zero-extended imm8 times four plus gbr, into index zero
// - pc long load: pc plus four, low two bits cleared, plus imm8 times four
// - pc load in a delay slot raises illegal slot before any memory access
// - pc load reports illegal slot, translation and protection faults; its address is always long aligned
// - displaced long load: imm4 times four plus source, into destination
// - indirect word store: low 16 bits of source at destination address
// - pre-decrement store: destination minus two, store, write decremented address back
// - indexed word store: index zero plus destination, low 16 bits of source
// - base word store: gbr plus imm8 times two, low 16 bits of index zero
// - displaced word store: destination plus imm4 times two, low half of index zero
// - indirect word load: 16 bits read, sign-extended, into destination
// - word stores report write address, translation, protection, first-write faults
// - post-increment with same register keeps loaded value, drops increment
// - post-increment long load: read at source, source plus four written back
`timescale 1ns/1ps
`default_nettype none
module word_long_load_store_agu
  import agu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       op_valid,
  output logic            op_ready,
  input  wire op_req_t    op_req,
  output logic            mem_req_valid,
  input  wire logic       mem_req_ready,
  output mem_req_t        mem_req,
  input  wire logic       mem_resp_valid,
  input  wire mem_resp_t  mem_resp,
  output logic            done,
  output exc_t            exception,
  output wb_t             wb_data,
  output wb_t             wb_addr
);

  typedef enum logic [1:0] {
    st_idle,
    st_access,
    st_resp
  } state_t;

  typedef struct packed {
    state_t      state;
    logic        is_load;
    logic [3:0]  dest_sel;
    logic        upd_en;
    logic [3:0]  upd_sel;
    logic [31:0] upd_value;
    mem_req_t    mem;
    logic        done;
    exc_t        exc;
    wb_t         wb_data;
    wb_t         wb_addr;
  } agu_state_t;

  localparam agu_state_t STATE_RESET = '{
    state:     st_idle,
    is_load:   1'b0,
    dest_sel:  4'h0,
    upd_en:    1'b0,
    upd_sel:   4'h0,
    upd_value: 32'h0,
    mem:       MEM_REQ_RESET,
    done:      1'b0,
    exc:       no_exception,
    wb_data:   WB_RESET,
    wb_addr:   WB_RESET
  };

  logic [1:0]  rst_sync_ff;
  logic        rst_n_int;
  agu_state_t  cur_ff;
  agu_state_t  nxt_cur;

  mem_req_t    ea_mem;
  logic        ea_is_load;
  logic        ea_misaligned;
  logic [3:0]  ea_dest_sel;
  logic        ea_upd_en;
  logic [3:0]  ea_upd_sel;
  logic [31:0] ea_upd_value;
  logic [31:0] load_value;

  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rst_sync_ff <= RESET_SYNC_INIT;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  assign rst_n_int = rst_sync_ff[1];

  agu_ea_calc u_ea_calc (
    .req        (op_req),
    .mem        (ea_mem),
    .is_load    (ea_is_load),
    .misaligned (ea_misaligned),
    .dest_sel   (ea_dest_sel),
    .upd_en     (ea_upd_en),
    .upd_sel    (ea_upd_sel),
    .upd_value  (ea_upd_value)
  );

  agu_load_extend u_load_extend (
    .rdata     (mem_resp.rdata),
    .size_long (cur_ff.mem.size_long),
    .value     (load_value)
  );

  // first fault reported by the memory side, translation before protection
  function automatic exc_t mem_fault(input mem_resp_t resp, input logic write);
    exc_t f;
    f = no_exception;
    if (write)
    begin
      if (resp.translation_miss)
        f = write_translation_miss;
      else if (resp.protection_violation)
        f = write_protection_violation;
      else if (resp.first_write)
        f = first_write_exception;
    end
    else
    begin
      if (resp.translation_miss)
        f = read_translation_miss;
      else if (resp.protection_violation)
        f = read_protection_violation;
    end
    return f;
  endfunction

  always_comb
  begin
    nxt_cur            = cur_ff;
    nxt_cur.done       = 1'b0;
    nxt_cur.wb_data.en = 1'b0;
    nxt_cur.wb_addr.en = 1'b0;
    case (cur_ff.state)
      st_idle:
      begin
        if (op_valid)
        begin
          nxt_cur.is_load   = ea_is_load;
          nxt_cur.dest_sel  = ea_dest_sel;
          nxt_cur.upd_en    = ea_upd_en;
          nxt_cur.upd_sel   = ea_upd_sel;
          nxt_cur.upd_value = ea_upd_value;
          nxt_cur.mem       = ea_mem;
          nxt_cur.exc       = no_exception;
          if (op_req.op == ld_long_pc && op_req.delay_slot)
          begin
            nxt_cur.done = 1'b1;
            nxt_cur.exc  = illegal_slot_exception;
          end
          else if (ea_misaligned)
          begin
            nxt_cur.done = 1'b1;
            nxt_cur.exc  = ea_mem.write ? write_address_error
                                        : read_address_error;
          end
          else
          begin
            nxt_cur.state = st_access;
          end
        end
      end
      st_access:
      begin
        if (mem_req_ready)
          nxt_cur.state = st_resp;
      end
      st_resp:
      begin
        if (mem_resp_valid)
        begin
          nxt_cur.state = st_idle;
          nxt_cur.done  = 1'b1;
          nxt_cur.exc   = mem_fault(mem_resp, cur_ff.mem.write);
          if (mem_fault(mem_resp, cur_ff.mem.write) == no_exception)
          begin
            if (cur_ff.is_load)
            begin
              nxt_cur.wb_data.en    = 1'b1;
              nxt_cur.wb_data.sel   = cur_ff.dest_sel;
              nxt_cur.wb_data.value = load_value;
            end
            // same register for both: loaded value wins, increment dropped
            if (cur_ff.upd_en && !(cur_ff.is_load && cur_ff.upd_sel == cur_ff.dest_sel))
            begin
              nxt_cur.wb_addr.en    = 1'b1;
              nxt_cur.wb_addr.sel   = cur_ff.upd_sel;
              nxt_cur.wb_addr.value = cur_ff.upd_value;
            end
          end
        end
      end
      default:
      begin
        nxt_cur.state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_int)
  begin
    if (!rst_n_int)
      cur_ff <= STATE_RESET;
    else
      cur_ff <= nxt_cur;
  end

  assign op_ready      = (cur_ff.state == st_idle);
  assign mem_req_valid = (cur_ff.state == st_access);
  assign mem_req       = cur_ff.mem;
  assign done          = cur_ff.done;
  assign exception     = cur_ff.exc;
  assign wb_data       = cur_ff.wb_data;
  assign wb_addr       = cur_ff.wb_addr;

endmodule // word_long_load_store_agu
`default_nettype wire
